// File: rtl/adc_readout_pkg.sv
// constants shared by the converter readout logic
package adc_readout_pkg;

	// core clock
	localparam longint unsigned CORE_CLK_HZ = 64'd250000000;
	localparam longint unsigned CORE_CLK_NS = 64'd4;

	// update rates in millihertz and settling times in milliseconds
	localparam longint unsigned RATE_FAST_MHZ = 64'd16700;
	localparam longint unsigned RATE_SLOW_MHZ = 64'd10000;
	localparam longint unsigned SETTLE_FAST_MS = 64'd120;
	localparam longint unsigned SETTLE_SLOW_MS = 64'd300;
	localparam longint unsigned OSC_START_MS = 64'd1;
	localparam longint unsigned READY_LEAD_NS = 64'd10000;

	// derived cycle counts (periods round down, waits round up)
	localparam longint unsigned PERIOD_FAST_CYC = CORE_CLK_HZ * 64'd1000 / RATE_FAST_MHZ;
	localparam longint unsigned PERIOD_SLOW_CYC = CORE_CLK_HZ * 64'd1000 / RATE_SLOW_MHZ;
	localparam longint unsigned SETTLE_FAST_CYC = (SETTLE_FAST_MS * CORE_CLK_HZ + 64'd999) / 64'd1000;
	localparam longint unsigned SETTLE_SLOW_CYC = (SETTLE_SLOW_MS * CORE_CLK_HZ + 64'd999) / 64'd1000;
	localparam longint unsigned OSC_START_CYC = (OSC_START_MS * CORE_CLK_HZ + 64'd999) / 64'd1000;
	localparam logic [31:0] READY_LEAD_CYC = 32'((READY_LEAD_NS + CORE_CLK_NS - 64'd1) / CORE_CLK_NS);

	// serial word layout: 20-bit result, four pad bits, then eight status bits
	localparam int WORD_BITS = 32;
	localparam int RESULT_BITS = 20;
	localparam logic [5:0] WORD_LAST = 6'h20;
	localparam logic [3:0] RESULT_PAD = 4'h0;
	localparam logic [1:0] STAT_ID = 2'h1; // arbitrary fixed pattern in the status byte

	// register byte offsets
	localparam logic [7:0] OFF_EVENT = 8'h00;
	localparam logic [7:0] OFF_MASK = 8'h04;
	localparam logic [7:0] OFF_STATE = 8'h08;
	localparam logic [7:0] OFF_RESULT = 8'h0C;
	localparam logic [7:0] OFF_CTRL = 8'h10;
	localparam logic [7:0] OFF_PATTERN = 8'h14;

	// event bits
	localparam int EV_DONE = 0;
	localparam int EV_MISSED = 1;
	localparam int EV_RESTART = 2;
	localparam int EV_READ = 3;
	localparam int EV_BITS = 4;

	// reset values and bus answers
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// conversion sequencer, gray coded along off, start, settle, run
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_START = 2'b01,
		ST_SETTLE = 2'b11,
		ST_RUN = 2'b10
	} conv_state_e;

endpackage

// File: rtl/serial_shifter.sv
// shift register that sends one 32-bit result word on falling shift clock edges
`timescale 1ns/10ps
module serial_shifter import adc_readout_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// control
	input wire logic clear,
	input wire logic load,
	input wire logic [31:0] word,
	// shift clock edges, already synchronised
	input wire logic sclk_fall,
	input wire logic sclk_rise,
	// outputs
	output logic sdata,
	output logic active,
	output logic done,
	output logic [5:0] bit_cnt
);

	logic [31:0] shift_reg;
	logic [5:0] cnt_reg;
	logic sdata_reg;
	logic active_reg;
	logic done_reg;
	logic shift_now;
	logic finish_now;

	// a bit leaves on each falling edge, the word ends on the next rising edge
	assign shift_now = sclk_fall && (cnt_reg != WORD_LAST);
	assign finish_now = sclk_rise && active_reg && (cnt_reg == WORD_LAST);

	// shift state
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_reg <= 32'h00000000;
			cnt_reg <= 6'h00;
			sdata_reg <= 1'b0;
			active_reg <= 1'b0;
		end else if (clear || load) begin
			shift_reg <= load ? word : 32'h00000000;
			cnt_reg <= 6'h00;
			active_reg <= 1'b0;
		end else if (shift_now) begin
			sdata_reg <= shift_reg[31];
			shift_reg <= {shift_reg[30:0], 1'b0};
			cnt_reg <= cnt_reg + 6'h01;
			active_reg <= 1'b1;
		end else if (finish_now) begin
			active_reg <= 1'b0;
		end
	end

	// completion pulse
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= finish_now && !clear && !load;
		end
	end

	assign sdata = sdata_reg;
	assign active = active_reg;
	assign done = done_reg;
	assign bit_cnt = cnt_reg;

endmodule

// File: rtl/adc_readout_top.sv
// pin-programmed converter control, ready/data serial output and register slave
`timescale 1ns/10ps
// Notes on behaviour
// - on each finished conversion the ready/data output is driven low
// - every read word carries eight status bits after the result
// - an unread result lets the ready/data output go high before the next update
// - each new result resets the serial interface, dropping any transfer under way
// - gain select low gives gain 128, high gives gain 1
// - rate select low: fast filter, 16.7 Hz updates, 120 ms settling
// - rate select high: rejection filter, 10 Hz updates, 300 ms settling
// - bridge switch closed while power-down/reset is high, open while low
// - power-down/reset low resets the conversion and serial logic, not the registers, and floats the ready/data output
// - after power-down/reset rises the device restarts and converts continuously
// - the oscillator gets about 1 ms to start before conversion begins
// - output data changes on the falling shift clock edge
// - a gain or rate select change restarts conversion with ready/data high
module adc_readout_top import adc_readout_pkg::*; #(
	parameter logic [31:0] PERIOD_FAST = PERIOD_FAST_CYC[31:0],
	parameter logic [31:0] PERIOD_SLOW = PERIOD_SLOW_CYC[31:0],
	parameter logic [31:0] SETTLE_FAST = SETTLE_FAST_CYC[31:0],
	parameter logic [31:0] SETTLE_SLOW = SETTLE_SLOW_CYC[31:0],
	parameter logic [31:0] OSC_START = OSC_START_CYC[31:0]
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// device pins
	input wire logic sclk,
	input wire logic powerdown_reset_n,
	input wire logic gain_sel,
	input wire logic filter_sel,
	output logic dout_o,
	output logic dout_oe,
	output logic bridge_switch,
	// modulator side
	input wire logic [19:0] modulator_result,
	output logic gain_128,
	output logic filter_fast,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [3:0] pin_in;
	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic sclk_d_reg;
	logic sclk_s;
	logic pd_s;
	logic gain_s;
	logic filter_s;

	assign pin_in = {filter_sel, gain_sel, powerdown_reset_n, sclk};

	// two flip-flops per pin
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta_reg[gi] <= 1'b0;
					sync_reg[gi] <= 1'b0;
				end else begin
					meta_reg[gi] <= pin_in[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	assign sclk_s = sync_reg[0];
	assign pd_s = sync_reg[1];
	assign gain_s = sync_reg[2];
	assign filter_s = sync_reg[3];

	////////////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	conv_state_e state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	logic gain_reg;
	logic filter_reg;
	logic ready_reg;
	logic dout_reg;
	logic oe_reg;
	logic bridge_reg;
	logic sclk_fall;
	logic sclk_rise;
	logic cfg_change;
	logic conv_done;
	logic lead_hit;
	logic [31:0] settle_cyc;
	logic [31:0] period_cyc;
	logic [31:0] word;
	logic [19:0] result_src;
	logic [19:0] result_reg;
	logic sh_data;
	logic sh_active;
	logic sh_done;
	logic [5:0] sh_cnt;
	logic ctrl_pattern_reg;
	logic [19:0] pattern_reg;

	assign sclk_fall = sclk_d_reg && !sclk_s;
	assign sclk_rise = !sclk_d_reg && sclk_s;
	assign cfg_change = (state_reg != ST_OFF) && ((gain_s != gain_reg) || (filter_s != filter_reg));
	assign settle_cyc = filter_s ? SETTLE_SLOW : SETTLE_FAST;
	assign period_cyc = filter_reg ? PERIOD_SLOW : PERIOD_FAST;
	assign conv_done = !cfg_change && (cnt_reg == 32'h00000000)
		&& ((state_reg == ST_SETTLE) || (state_reg == ST_RUN));
	assign lead_hit = (state_reg == ST_RUN) && ready_reg && (cnt_reg == READY_LEAD_CYC);
	assign result_src = ctrl_pattern_reg ? pattern_reg : modulator_result;
	// result, pad, then status byte: ready, error, zeros, rate, gain, id
	assign word = {result_src, RESULT_PAD, 1'b0, 1'b0, 2'b00, filter_reg, gain_reg, STAT_ID};

	// next state and timer
	always_comb begin
		state_next = state_reg;
		cnt_next = (cnt_reg == 32'h00000000) ? cnt_reg : cnt_reg - 32'h00000001;
		unique case (state_reg)
			ST_OFF: begin
				state_next = ST_START;
				cnt_next = OSC_START;
			end
			ST_START: begin
				if (cnt_reg == 32'h00000000) begin
					state_next = ST_SETTLE;
					cnt_next = settle_cyc;
				end
			end
			ST_SETTLE, ST_RUN: begin
				if (cfg_change) begin
					state_next = ST_SETTLE;
					cnt_next = settle_cyc;
				end else if (conv_done) begin
					state_next = ST_RUN;
					cnt_next = period_cyc - 32'h00000001; // reload edge counts as one cycle
				end
			end
		endcase
	end

	// sequencer registers, held in reset while power-down/reset is low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_OFF;
			cnt_reg <= 32'h00000000;
			gain_reg <= 1'b0;
			filter_reg <= 1'b0;
			sclk_d_reg <= 1'b0;
		end else if (!pd_s) begin
			state_reg <= ST_OFF;
			cnt_reg <= 32'h00000000;
			gain_reg <= gain_s;
			filter_reg <= filter_s;
			sclk_d_reg <= sclk_s;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			gain_reg <= gain_s;
			filter_reg <= filter_s;
			sclk_d_reg <= sclk_s;
		end
	end

	// ready flag and result register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_reg <= 1'b0;
			result_reg <= 20'h00000;
		end else if (!pd_s || cfg_change || lead_hit || sh_done) begin
			ready_reg <= 1'b0;
		end else if (conv_done) begin
			ready_reg <= 1'b1;
			result_reg <= result_src;
		end
	end

	// pin drivers
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dout_reg <= 1'b1;
			oe_reg <= 1'b0;
			bridge_reg <= 1'b0;
		end else begin
			oe_reg <= pd_s;
			bridge_reg <= pd_s;
			if (!pd_s || cfg_change || lead_hit || sh_done) begin
				dout_reg <= 1'b1;
			end else if (conv_done) begin
				dout_reg <= 1'b0;
			end else if (ready_reg && sh_active) begin
				dout_reg <= sh_data;
			end
		end
	end

	// serial word shifter, cleared on each result and on any restart
	serial_shifter u_shift (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clear(!pd_s || cfg_change || lead_hit),
		.load(conv_done),
		.word(word),
		.sclk_fall(sclk_fall && ready_reg),
		.sclk_rise(sclk_rise),
		.sdata(sh_data),
		.active(sh_active),
		.done(sh_done),
		.bit_cnt(sh_cnt)
	);

	assign dout_o = dout_reg;
	assign dout_oe = oe_reg;
	assign bridge_switch = bridge_reg;
	assign gain_128 = !gain_reg;
	assign filter_fast = !filter_reg;

	////////////////////////////////////////////////////////////////////////////////
	// register slave and interrupt

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr[7:2] == off[7:2]);
	endfunction

	logic [7:0] awaddr_reg;
	logic aw_have_reg;
	logic w_have_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [3:0] event_reg;
	logic [3:0] mask_reg;
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic wr_go;
	logic wr_map;
	logic [31:0] rd_val;
	logic rd_map;

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready = !w_have_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_map = hit(awaddr_reg, OFF_EVENT) || hit(awaddr_reg, OFF_MASK)
		|| hit(awaddr_reg, OFF_CTRL) || hit(awaddr_reg, OFF_PATTERN);
	assign ev_set = {sh_done, cfg_change, lead_hit, conv_done};
	assign ev_clr = (wr_go && hit(awaddr_reg, OFF_EVENT) && wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0;
	assign rd_map = hit(s_axi_araddr, OFF_EVENT) || hit(s_axi_araddr, OFF_MASK)
		|| hit(s_axi_araddr, OFF_STATE) || hit(s_axi_araddr, OFF_RESULT)
		|| hit(s_axi_araddr, OFF_CTRL) || hit(s_axi_araddr, OFF_PATTERN);
	assign rd_val = hit(s_axi_araddr, OFF_EVENT) ? {28'h0000000, event_reg}
		: hit(s_axi_araddr, OFF_MASK) ? {28'h0000000, mask_reg}
		: hit(s_axi_araddr, OFF_STATE) ? {24'h000000, pd_s, ready_reg, state_reg,
			filter_reg, gain_reg, sh_active, dout_reg}
		: hit(s_axi_araddr, OFF_RESULT) ? {12'h000, result_reg}
		: hit(s_axi_araddr, OFF_CTRL) ? {31'h00000000, ctrl_pattern_reg}
		: hit(s_axi_araddr, OFF_PATTERN) ? {12'h000, pattern_reg}
		: 32'h00000000;

	// write address and data capture, response after both
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// writable registers; a new event wins over its clear
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			event_reg <= 4'h0;
			mask_reg <= MASK_RST;
			ctrl_pattern_reg <= 1'b0;
			pattern_reg <= 20'h00000;
		end else begin
			event_reg <= (event_reg & ~ev_clr) | ev_set;
			if (wr_go && hit(awaddr_reg, OFF_MASK) && wstrb_reg[0]) begin
				mask_reg <= wdata_reg[3:0];
			end
			if (wr_go && hit(awaddr_reg, OFF_CTRL) && wstrb_reg[0]) begin
				ctrl_pattern_reg <= wdata_reg[0];
			end
			if (wr_go && hit(awaddr_reg, OFF_PATTERN)) begin
				pattern_reg[7:0] <= wstrb_reg[0] ? wdata_reg[7:0] : pattern_reg[7:0];
				pattern_reg[15:8] <= wstrb_reg[1] ? wdata_reg[15:8] : pattern_reg[15:8];
				pattern_reg[19:16] <= wstrb_reg[2] ? wdata_reg[19:16] : pattern_reg[19:16];
			end
		end
	end

	// read channel
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_val;
			rresp_reg <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq = |(event_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	// cycles spent waiting for the oscillator, for the start-up check
	logic [31:0] osc_cnt_reg;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			osc_cnt_reg <= 32'h00000000;
		end else if (state_reg == ST_START) begin
			osc_cnt_reg <= osc_cnt_reg + 32'h00000001;
		end else begin
			osc_cnt_reg <= 32'h00000000;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_power_rise;
		!pd_s ##1 pd_s;
	endsequence
	sequence s_osc_leave;
		(state_reg == ST_START) ##1 (state_reg == ST_SETTLE);
	endsequence

	a_ready_on_done: assert property (conv_done && pd_s |=> !dout_o && dout_oe && ready_reg)
		else $error("ready/data not low after conversion");
	a_status_byte: assert property (conv_done && pd_s |=> u_shift.shift_reg[7:0]
		== {4'h0, $past(filter_reg), $past(gain_reg), STAT_ID})
		else $error("status byte missing from word");
	a_lead_high: assert property (lead_hit && pd_s |=> dout_o && !ready_reg)
		else $error("unread result kept ready low");
	a_serial_reset: assert property (conv_done && pd_s |=> sh_cnt == 6'h00 && !sh_active)
		else $error("serial state not reset on new result");
	a_gain_map: assert property (##1 gain_128 == !$past(gain_s) || $past(cfg_change))
		else $error("gain select mapping wrong");
	a_settle_load: assert property (cfg_change && pd_s && state_reg != ST_START
		|=> cnt_reg == $past(settle_cyc)
		&& state_reg == ST_SETTLE && dout_o)
		else $error("settling not restarted on select change");
	a_bridge_follow: assert property (s_power_rise |=> bridge_switch && dout_oe)
		else $error("bridge switch or output not enabled");
	a_pd_float: assert property (!pd_s |=> !dout_oe && !bridge_switch && !ready_reg)
		else $error("output driven in power-down");
	a_osc_wait: assert property (s_osc_leave |-> osc_cnt_reg >= OSC_START)
		else $error("oscillator start time cut short");
	a_shift_fall: assert property (sclk_fall && ready_reg && sh_cnt != WORD_LAST
		&& !conv_done && !cfg_change && !lead_hit && pd_s |=> sh_active)
		else $error("falling shift edge did not advance data");

endmodule

// File: verification/host_reader.sv
// host side model that clocks the result word out of the ready/data pin
`timescale 1ns/10ps
module host_reader (
	// link pins
	output logic sclk,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic last_lvl;
	logic pin;

	////////////////////////////////////////////////////////////////
	// a floated pin shows the inverse of its last driven level
	assign pin = dout_oe ? dout_o : ~last_lvl;
	always @(dout_o or dout_oe) begin
		if (dout_oe)
			last_lvl = dout_o;
	end

	// shift clock stands high outside frames
	initial begin
		sclk = 1'b1;
		last_lvl = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// n bits msb first; data moves on the fall, sampled late in the high phase
	task automatic shift(input int n, inout logic [31:0] w);
		#1.3;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b0;
			#16;
			sclk = 1'b1;
			#12;
			w = {w[30:0], pin};
			#4;
		end
	endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the converter readout block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %0h got %0h", nm, (e), (g)); end end
module tb_top import adc_readout_pkg::*;;
	localparam logic [31:0] P_OSC = 32'h14;
	localparam logic [31:0] P_SF = 32'hC8;
	localparam logic [31:0] P_SS = 32'h12C;
	localparam logic [31:0] P_PF = 32'hFA0;
	localparam logic [31:0] P_PS = 32'h1388;
	logic core_clk, sys_rst, sclk, powerdown_reset_n, gain_sel, filter_sel;
	logic dout_o, dout_oe, bridge_switch, gain_128, filter_fast, irq;
	logic [19:0] modulator_result;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, w, d, e;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int error_cnt = 0;
	int n_tests = 0;
	int n, n1, n2;

	////////////////////////////////////////////////////////////////
	// block under test with shortened counts, and the host model
	adc_readout_top #(.PERIOD_FAST(P_PF), .PERIOD_SLOW(P_PS), .SETTLE_FAST(P_SF),
		.SETTLE_SLOW(P_SS), .OSC_START(P_OSC)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.sclk(sclk), .powerdown_reset_n(powerdown_reset_n), .gain_sel(gain_sel),
		.filter_sel(filter_sel), .dout_o(dout_o), .dout_oe(dout_oe),
		.bridge_switch(bridge_switch), .modulator_result(modulator_result),
		.gain_128(gain_128), .filter_fast(filter_fast), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq(irq));
	host_reader host (.sclk(sclk), .dout_o(dout_o), .dout_oe(dout_oe));

	// core clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////
	// closing report and hang handling
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic give_up(input string what);
		error_cnt++;
		$display("wrong value %s exp answer got timeout", what);
		report_and_stop();
	endtask

	// count core edges until the ready/data pin shows level v
	task automatic wait_lvl(input logic v, input int lim, output int cnt);
		cnt = 0;
		while (dout_o !== v) begin
			@(posedge core_clk);
			cnt++;
			if (cnt > lim)
				give_up("ready pin");
		end
	endtask

	function automatic logic [31:0] exp_word(input logic f, input logic g);
		return {modulator_result, RESULT_PAD, 4'h0, f, g, STAT_ID};
	endfunction

	////////////////////////////////////////////////////////////////
	// register bus master: both write channels offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
		int k;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= dat;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (k == 50)
			give_up("write answer");
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		int k;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		if (k == 50)
			give_up("read answer");
		dat = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	// register reset value and unmapped addresses
	task automatic t_regs();
		axi_rd(OFF_MASK, d, r);
		`CHK("mask reset", {28'h0, MASK_RST}, d)
		axi_rd(8'h40, d, r);
		`CHK("unmapped read resp", RESP_SLVERR, r)
		`CHK("unmapped read data", 32'h0, d)
		axi_wr(8'h40, 32'hFFFFFFFF, r);
		`CHK("unmapped write resp", RESP_SLVERR, r)
	endtask

	// first result: ready low, full word, events and interrupt
	task automatic t_first();
		wait_lvl(1'b0, 2000, n);
		`CHK("pin enable", 1'b1, dout_oe)
		e = exp_word(1'b0, 1'b0);
		host.shift(32, w);
		`CHK("result word", e, w)
		wait_lvl(1'b1, 12, n);
		axi_wr(OFF_MASK, 32'h8, r);
		`CHK("irq raised", 1'b1, irq)
		axi_rd(OFF_EVENT, d, r);
		`CHK("done and read events", 2'b11, {d[EV_DONE], d[EV_READ]})
		axi_wr(OFF_EVENT, 32'h8, r);
		`CHK("irq cleared", 1'b0, irq)
		axi_wr(OFF_MASK, 32'h0, r);
	endtask

	// select change while ready, settling, word, then unread period
	task automatic t_sel(input logic f, input logic g, input int settle, input int period);
		wait_lvl(1'b0, 6000, n);
		@(posedge core_clk);
		filter_sel <= f;
		gain_sel <= g;
		wait_lvl(1'b1, 8, n);
		wait_lvl(1'b0, settle + 40, n);
		`CHK("settling", 1'b1, n >= settle - 4 && n <= settle + 8)
		e = exp_word(f, g);
		host.shift(32, w);
		`CHK("word after change", e, w)
		`CHK("gain output", ~g, gain_128)
		`CHK("filter output", ~f, filter_fast)
		wait_lvl(1'b1, 12, n);
		wait_lvl(1'b0, period, n);
		wait_lvl(1'b1, period, n1);
		wait_lvl(1'b0, period, n2);
		`CHK("update period", period, n1 + n2)
		`CHK("ready lead", 1'b1, n2 >= 2498 && n2 <= 2502)
		axi_rd(OFF_EVENT, d, r);
		`CHK("restart and missed", 2'b11, {d[EV_RESTART], d[EV_MISSED]})
		axi_wr(OFF_EVENT, 32'hF, r);
	endtask

	// partial read in bursts, dropped, then a fresh whole word
	task automatic t_abort();
		wait_lvl(1'b0, 6000, n);
		e = exp_word(1'b0, 1'b0);
		w = 32'h0;
		host.shift(8, w);
		#100;
		host.shift(8, w);
		`CHK("burst bits", e[31:16], w[15:0])
		@(posedge core_clk);
		modulator_result <= 20'h5A0F1;
		wait_lvl(1'b1, 6000, n);
		wait_lvl(1'b0, 6000, n);
		e = exp_word(1'b0, 1'b0);
		host.shift(24, w);
		host.shift(8, w);
		`CHK("word after abort", e, w)
	endtask

	// power-down pulse, float, restart and continuous conversion
	task automatic t_pd();
		@(posedge core_clk);
		powerdown_reset_n <= 1'b0;
		repeat (30) @(posedge core_clk);
		`CHK("pin floats", 1'b0, dout_oe)
		`CHK("switch open", 1'b0, bridge_switch)
		axi_rd(OFF_STATE, d, r);
		`CHK("off state", 3'b000, {d[7], d[5:4]})
		powerdown_reset_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		`CHK("switch closed", 1'b1, bridge_switch)
		wait_lvl(1'b0, 400, n);
		`CHK("restart time", 1'b1, n + 8 >= P_OSC + P_SF && n + 8 <= P_OSC + P_SF + 10)
		`CHK("pin driven", 1'b1, dout_oe)
		e = exp_word(1'b0, 1'b0);
		host.shift(32, w);
		`CHK("word after restart", e, w)
		wait_lvl(1'b1, 12, n);
		wait_lvl(1'b0, 6000, n);
	endtask

	// test pattern in place of the modulator result, and the result register
	task automatic t_pat();
		axi_wr(OFF_PATTERN, 32'h0003C5A9, r);
		`CHK("pattern write resp", RESP_OKAY, r)
		axi_wr(OFF_CTRL, 32'h1, r);
		wait_lvl(1'b1, 6000, n);
		wait_lvl(1'b0, 6000, n);
		e = {20'h3C5A9, RESULT_PAD, 4'h0, 2'b00, STAT_ID};
		host.shift(32, w);
		`CHK("pattern word", e, w)
		axi_rd(OFF_RESULT, d, r);
		`CHK("result register", 32'h0003C5A9, d)
		axi_wr(OFF_CTRL, 32'h0, r);
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		sys_rst = 1'b1;
		powerdown_reset_n = 1'b1;
		gain_sel = 1'b0;
		filter_sel = 1'b0;
		modulator_result = 20'hA5C3E;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_first();
		t_sel(1'b1, 1'b1, P_SS, P_PS);
		t_sel(1'b0, 1'b0, P_SF, P_PF);
		t_abort();
		t_pd();
		t_pat();
		report_and_stop();
	end
endmodule
